// *** aomc_pkg.sv ***
// package: constants, register map and carrier types of the converter output mode control
`default_nettype none

package aomc_pkg;
	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int unsigned AOMC_DATA_W = 12;
	localparam int unsigned AOMC_PIPE_DEPTH = 7;
	localparam int unsigned AOMC_CLK_MHZ = 100;
	localparam int unsigned AOMC_RELOCK_CYCLES = 100;
	localparam logic [6:0] AOMC_RELOCK_CNT = 7'(AOMC_RELOCK_CYCLES);

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] AOMC_CTRL_OFF = 4'h0;
	localparam logic [3:0] AOMC_STAT_OFF = 4'h4;
	localparam logic [3:0] AOMC_DATA_OFF = 4'h8;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned AOMC_CTRL_POWER_DOWN_INPUT_BIT = 0;
	localparam int unsigned AOMC_STAT_TWOS_BIT = 0;
	localparam int unsigned AOMC_STAT_DCS_BIT = 1;
	localparam int unsigned AOMC_STAT_REF_LSB = 2;
	localparam int unsigned AOMC_STAT_LOCK_BIT = 4;
	localparam int unsigned AOMC_STAT_PD_BIT = 5;
	localparam logic AOMC_CTRL_POWER_DOWN_INPUT_RST = 1'b0;

	// strap levels as seen by the comparators
	typedef enum logic [1:0] {
		AOMC_LVL_GND = 2'h0,
		AOMC_LVL_THIRD = 2'h1,
		AOMC_LVL_TWO_THIRDS = 2'h2,
		AOMC_LVL_SUPPLY = 2'h3
	} aomc_level_type;

	// reference states
	typedef enum logic [1:0] {
		AOMC_REF_1V0 = 2'h0,
		AOMC_REF_PROG = 2'h1,
		AOMC_REF_0V5 = 2'h2,
		AOMC_REF_EXT = 2'h3
	} aomc_ref_type;

	typedef struct packed {
		logic twos_complement;
		logic duty_cycle_stabilizer;
	} aomc_mode_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} aomc_wb_req_type;
endpackage : aomc_pkg

`default_nettype wire

// *** aomc_core.sv ***
// top module: sample pipeline, strap decode, standby and wishbone registers
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`default_nettype none

module aomc_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [11:0] sample_i,
	input wire aomc_pkg::aomc_level_type mode_level_i,
	input wire aomc_pkg::aomc_level_type ref_level_i,
	input wire logic power_down_input_i,
	input wire aomc_pkg::aomc_wb_req_type wb_req_i,
	output logic [11:0] data_o,
	output logic [11:0] data_oe_o,
	output logic [1:0] ref_state_o,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o
);
	typedef struct packed {
		logic [aomc_pkg::AOMC_PIPE_DEPTH-1:0][11:0] pipe;
		logic [11:0] dout;
		logic [11:0] oe;
		aomc_pkg::aomc_mode_type mode;
		aomc_pkg::aomc_ref_type refs;
		logic ctrl_pd;
		logic [6:0] lock_cnt;
		logic [1:0] last_period;
		logic ack;
		logic [31:0] rdat;
		logic [3:0] fill;
	} aomc_state_type;

	aomc_state_type st_r;
	aomc_state_type st_nxt;
	logic standby;
	logic bus_go;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// msb flip maps offset binary onto twos complement
	function automatic logic [11:0] aomc_format(input logic [11:0] v, input logic twos);
		aomc_format = twos ? {~v[11], v[10:0]} : v;
	endfunction : aomc_format

	function automatic aomc_pkg::aomc_mode_type aomc_decode_mode(input aomc_pkg::aomc_level_type l);
		aomc_pkg::aomc_mode_type m;
		case (l)
			aomc_pkg::AOMC_LVL_SUPPLY: m = '{twos_complement: 1'b1, duty_cycle_stabilizer: 1'b0};
			aomc_pkg::AOMC_LVL_TWO_THIRDS: m = '{twos_complement: 1'b1, duty_cycle_stabilizer: 1'b1};
			aomc_pkg::AOMC_LVL_THIRD: m = '{twos_complement: 1'b0, duty_cycle_stabilizer: 1'b1};
			default: m = '{twos_complement: 1'b0, duty_cycle_stabilizer: 1'b0};
		endcase
		aomc_decode_mode = m;
	endfunction : aomc_decode_mode

	function automatic aomc_pkg::aomc_ref_type aomc_decode_ref(input aomc_pkg::aomc_level_type l);
		aomc_pkg::aomc_ref_type r;
		case (l)
			aomc_pkg::AOMC_LVL_SUPPLY: r = aomc_pkg::AOMC_REF_EXT;
			aomc_pkg::AOMC_LVL_TWO_THIRDS: r = aomc_pkg::AOMC_REF_0V5;
			aomc_pkg::AOMC_LVL_THIRD: r = aomc_pkg::AOMC_REF_PROG;
			default: r = aomc_pkg::AOMC_REF_1V0;
		endcase
		aomc_decode_ref = r;
	endfunction : aomc_decode_ref

	assign standby = power_down_input_i | st_r.ctrl_pd;
	assign bus_go = wb_req_i.cyc & wb_req_i.stb & ~st_r.ack;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// pipeline keeps shifting in standby so no stale word escapes on wake
	always_comb begin
		st_nxt = st_r;
		st_nxt.pipe = {st_r.pipe[aomc_pkg::AOMC_PIPE_DEPTH-2:0], sample_i};
		// last stage feeds the output flop, so a word leaves seven edges after entry
		st_nxt.dout = aomc_format(st_r.pipe[aomc_pkg::AOMC_PIPE_DEPTH-1],
			st_r.mode.twos_complement);
		// clean edges since reset, saturating; lets the latency check skip the fill
		if (st_r.fill != 4'h9) begin
			st_nxt.fill = st_r.fill + 4'h1;
		end
		st_nxt.oe = standby ? 12'h000 : 12'hfff;
		st_nxt.mode = aomc_decode_mode(mode_level_i);
		st_nxt.refs = aomc_decode_ref(ref_level_i);
		// relock count restarts when stabilizer is switched on
		if (st_nxt.mode.duty_cycle_stabilizer & ~st_r.mode.duty_cycle_stabilizer) begin
			st_nxt.lock_cnt = aomc_pkg::AOMC_RELOCK_CNT;
		end else if (st_r.lock_cnt != 7'h00) begin
			st_nxt.lock_cnt = st_r.lock_cnt - 7'h01;
		end
		st_nxt.ack = bus_go;
		st_nxt.rdat = 32'h0000_0000;
		if (bus_go) begin
			if (wb_req_i.we) begin
				if (wb_req_i.adr == aomc_pkg::AOMC_CTRL_OFF && wb_req_i.sel[0]) begin
					st_nxt.ctrl_pd = wb_req_i.dat[aomc_pkg::AOMC_CTRL_POWER_DOWN_INPUT_BIT];
				end
			end else begin
				case (wb_req_i.adr)
					aomc_pkg::AOMC_CTRL_OFF: st_nxt.rdat[aomc_pkg::AOMC_CTRL_POWER_DOWN_INPUT_BIT] = st_r.ctrl_pd;
					aomc_pkg::AOMC_STAT_OFF: begin
						st_nxt.rdat[aomc_pkg::AOMC_STAT_TWOS_BIT] = st_r.mode.twos_complement;
						st_nxt.rdat[aomc_pkg::AOMC_STAT_DCS_BIT] = st_r.mode.duty_cycle_stabilizer;
						st_nxt.rdat[aomc_pkg::AOMC_STAT_REF_LSB +: 2] = st_r.refs;
						st_nxt.rdat[aomc_pkg::AOMC_STAT_LOCK_BIT] = (st_r.lock_cnt == 7'h00);
						st_nxt.rdat[aomc_pkg::AOMC_STAT_PD_BIT] = standby;
					end
					aomc_pkg::AOMC_DATA_OFF: st_nxt.rdat[11:0] = st_r.dout;
					default: st_nxt.rdat = 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.ctrl_pd <= aomc_pkg::AOMC_CTRL_POWER_DOWN_INPUT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign data_o = st_r.dout;
	assign data_oe_o = st_r.oe;
	assign ref_state_o = st_r.refs;
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdat;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// seen at an edge, the output word was launched one edge earlier, hence depth eight
	a_pipe_latency: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.fill >= 4'h8 && !$past(st_r.mode.twos_complement)
		|-> data_o == $past(sample_i, 8))
		else $error("output word not the sample of seven clocks before");
	a_twos_latency: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.fill >= 4'h8 && $past(st_r.mode.twos_complement)
		|-> data_o == {~$past(sample_i[11], 8), $past(sample_i[10:0], 8)})
		else $error("twos complement word not msb flipped sample");
	a_mode_supply: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_level_i == aomc_pkg::AOMC_LVL_SUPPLY |=> st_r.mode == 2'b10)
		else $error("full supply strap must give twos complement, stabilizer off");
	a_mode_thirds: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_level_i == aomc_pkg::AOMC_LVL_TWO_THIRDS |=> st_r.mode == 2'b11)
		else $error("two thirds strap must give twos complement, stabilizer on");
	a_mode_third: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_level_i == aomc_pkg::AOMC_LVL_THIRD |=> st_r.mode == 2'b01)
		else $error("one third strap must give offset binary, stabilizer on");
	a_mode_ground: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_level_i == aomc_pkg::AOMC_LVL_GND |=> st_r.mode == 2'b00)
		else $error("grounded strap must give offset binary, stabilizer off");
	a_ref_ext: assert property (@(posedge clk_i) disable iff (rst_i)
		ref_level_i == aomc_pkg::AOMC_LVL_SUPPLY |=> ref_state_o == aomc_pkg::AOMC_REF_EXT)
		else $error("full supply reference select must pick external");
	a_ref_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
		ref_level_i == aomc_pkg::AOMC_LVL_GND |=> ref_state_o == aomc_pkg::AOMC_REF_1V0)
		else $error("grounded reference select must pick 1.0 V");
	a_standby_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
		power_down_input_i |=> data_oe_o == 12'h000)
		else $error("outputs must float during standby");
	// software standby must float the bus exactly as the pin does
	a_soft_standby: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.ctrl_pd |=> data_oe_o == 12'h000)
		else $error("outputs must float during software standby");
	a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_go && wb_req_i.we && wb_req_i.adr == aomc_pkg::AOMC_CTRL_OFF && wb_req_i.sel[0]
		|=> st_r.ctrl_pd == $past(wb_req_i.dat[aomc_pkg::AOMC_CTRL_POWER_DOWN_INPUT_BIT]))
		else $error("control write did not land");
	a_ref_half: assert property (@(posedge clk_i) disable iff (rst_i)
		ref_level_i == aomc_pkg::AOMC_LVL_TWO_THIRDS |=> ref_state_o == aomc_pkg::AOMC_REF_0V5)
		else $error("reference tied to its output must pick 0.5 V");
	a_ref_prog: assert property (@(posedge clk_i) disable iff (rst_i)
		ref_level_i == aomc_pkg::AOMC_LVL_THIRD |=> ref_state_o == aomc_pkg::AOMC_REF_PROG)
		else $error("divider reference select must pick programmable");
	a_wake_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		!power_down_input_i && !st_r.ctrl_pd |=> data_oe_o == 12'hfff)
		else $error("outputs must drive in normal operation");
	a_relock_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(st_r.mode.duty_cycle_stabilizer) |-> st_r.lock_cnt == aomc_pkg::AOMC_RELOCK_CNT)
		else $error("relock count not restarted");
	// count must fall by one each clock while nonzero, unless restarted
	a_relock_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.lock_cnt != 7'h00 ##1 !$rose(st_r.mode.duty_cycle_stabilizer)
		|-> st_r.lock_cnt == $past(st_r.lock_cnt) - 7'h01)
		else $error("relock count not counting down");
	// bus answers a taken request on the very next edge
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_go |=> wb_ack_o)
		else $error("request not acknowledged in one cycle");
	// read data is only valid alongside ack, zero otherwise
	a_rdat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");
endmodule : aomc_core

`default_nettype wire

// *** aomc_capture.sv ***
// downstream capture register that receives the converter's output words
`default_nettype none

module aomc_capture (
	input wire logic clk_i,
	input wire logic [11:0] bus_i,
	input wire logic [11:0] oe_i,
	input wire logic twos_i,
	output logic [11:0] word_o
);
	logic [11:0] last_r;
	logic [11:0] wire_lvl;
	// released bits have no pull, so they flip every cycle instead of holding
	assign wire_lvl = (bus_i & oe_i) | (~last_r & ~oe_i);
	// captured on the rising edge, well after the previous word settled
	always_ff @(posedge clk_i) begin
		last_r <= wire_lvl;
		word_o <= twos_i ? (wire_lvl ^ 12'h800) : wire_lvl;
	end
endmodule : aomc_capture

`default_nettype wire

// *** aomc_core_tb.sv ***
// testbench: pipeline, strap decode, standby and register access
`default_nettype none

module aomc_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, pd_pin, twos_x, wb_ack_o;
	logic [11:0] sample_i, data_o, data_oe_o, cap_word;
	logic [11:0] hist [0:8];
	logic [1:0] ref_state_o;
	logic [31:0] wb_dat_o, rd;
	aomc_pkg::aomc_level_type mode_lvl, ref_lvl;
	aomc_pkg::aomc_wb_req_type wb_req;
	int err_total, total_checks, cyc_cnt;

	aomc_core aomc_core_inst (.clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_i),
		.mode_level_i(mode_lvl), .ref_level_i(ref_lvl), .power_down_input_i(pd_pin),
		.wb_req_i(wb_req), .data_o(data_o), .data_oe_o(data_oe_o),
		.ref_state_o(ref_state_o), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
	aomc_capture aomc_capture_inst (.clk_i(clk_i), .bus_i(data_o), .oe_i(data_oe_o),
		.twos_i(twos_x), .word_o(cap_word));

	// twos complement only on the two upper strap levels
	assign twos_x = (mode_lvl == aomc_pkg::AOMC_LVL_SUPPLY) ||
		(mode_lvl == aomc_pkg::AOMC_LVL_TWO_THIRDS);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// stimulus, sample history and timeout
	// ----------------------------------------
	always @(posedge clk_i) begin
		sample_i <= sample_i + 12'h135; // odd step walks through the msb often
		hist[0] <= sample_i;
		for (int i = 1; i < 9; i++) hist[i] <= hist[i-1];
		cyc_cnt++;
		if (cyc_cnt > 3000) begin
			err_total++;
			close_out();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// classic cycle: hold until ack is sampled high, then release
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_req <= '0;
	endtask : wb

	task run_chk(input int n);
		repeat (n) begin
			@(posedge clk_i);
			#1;
			chk("data", {20'h0, hist[7] ^ {twos_x, 11'h0}}, {20'h0, data_o});
			chk("capture", {20'h0, hist[8]}, {20'h0, cap_word});
		end
	endtask : run_chk

	task close_out();
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out

	initial begin
		{err_total, total_checks, cyc_cnt} = '0;
		{rst_i, pd_pin, sample_i, wb_req} = {1'b1, 1'b0, 12'h0, 43'h0};
		mode_lvl = aomc_pkg::AOMC_LVL_GND;
		ref_lvl = aomc_pkg::AOMC_LVL_GND;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, aomc_pkg::AOMC_CTRL_OFF, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		// every strap level of both comparators
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_i);
			mode_lvl <= aomc_pkg::aomc_level_type'(m[1:0]);
			ref_lvl <= aomc_pkg::aomc_level_type'(m[1:0]);
			repeat (12) @(posedge clk_i);
			run_chk(10);
			chk("ref", m, ref_state_o);
			wb(1'b0, aomc_pkg::AOMC_STAT_OFF, 32'h0);
			chk("status", {m[1:0], m == 1 || m == 2, m >= 2}, rd[3:0]);
		end
		// stabilizer turned on: lock after the relock count
		mode_lvl <= aomc_pkg::AOMC_LVL_THIRD;
		wb(1'b0, aomc_pkg::AOMC_STAT_OFF, 32'h0);
		chk("unlocked", 1'b0, rd[4]);
		repeat (100) @(posedge clk_i);
		wb(1'b0, aomc_pkg::AOMC_STAT_OFF, 32'h0);
		chk("locked", 1'b1, rd[4]);
		// standby by pin, then by software
		pd_pin <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk("oe pin", 12'h0, data_oe_o);
		wb(1'b0, aomc_pkg::AOMC_STAT_OFF, 32'h0);
		chk("standby", 1'b1, rd[5]);
		pd_pin <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1 chk("oe back", 12'hfff, data_oe_o);
		wb(1'b1, aomc_pkg::AOMC_CTRL_OFF, 32'h1);
		repeat (2) @(posedge clk_i);
		#1 chk("oe soft", 12'h0, data_oe_o);
		wb(1'b0, aomc_pkg::AOMC_CTRL_OFF, 32'h0);
		chk("ctrl", 32'h1, rd);
		wb(1'b1, aomc_pkg::AOMC_CTRL_OFF, 32'h0);
		// unmapped place: writes dropped, reads zero
		wb(1'b1, 4'hc, 32'hffffffff);
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, rd);
		repeat (12) @(posedge clk_i);
		run_chk(10);
		close_out();
	end
endmodule : aomc_core_tb

`default_nettype wire
